// ===== lfd_monitor.sv
// Fault qualification, latched flags, error-pin drive, config CRC and watchdog.
// Assumes comparator levels and host strobes are synchronous to ref_clk.
`timescale 1ns/100ps

// What this block does
// R1 - Qualified open sets flags, pulses error pin
// R2 - Open qualified only inside long PWM on-time
// R3 - Low supply blocks open detection
// R4 - Faults only reported, no output action
// R5 - Flags latch until self-clearing clear strobe
// R6 - Qualified short sets flags, pulses error pin
// R7 - Short qualified only inside long on-time
// R8 - Single-short detection needs its enable
// R9 - Qualified single short sets flags, pulses
// R10 - Short on-times never give single-short report
// R11 - Select between two thresholds, applied from channel 0 only to chan_level_code
// R12 - Thresholds 8-bit codes, 125 mV steps
// R13 - Single-short removal needs threshold plus hysteresis, or low supply
// R14 - Post-load CRC mismatch flags and pulses
// R15 - CRC-8 poly 0x31, init FFh, MSB first
// R16 - Restore defaults reloads and reruns CRC
// R17 - Trim parity error sets parity flag
// R18 - Watchdog counts idle, restarts on good frame
// R19 - Overflow sets fail-safe, host clear returns
// R20 - Period Fh forces fail-safe, 0h disables
// R21 - Masks keep flags, stop summary propagation
// R22 - Hard faults hold pin, warnings pulse
// R23 - Channel diag disable blocks all reporting
// R24 - Per-type LED masks gate summary flags
// R25 - Counters time pulse, blanking, deglitch
module lfd_monitor
  import lfd_pkg::*;
#(
  parameter int NCH = NUM_CHAN,
  parameter int ERR_CYC = ERR_PULSE_CYC,
  parameter int WDT_TICK = WDT_TICK_DEF
)
(
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [NCH-1:0] chan_pwm_on, // PWM on-time per channel
  input wire logic [NCH-1:0] chan_diag_enable, // Per-channel diagnosis enable
  input wire logic [NCH-1:0] open_cmp, // Headroom below open threshold
  input wire logic [NCH-1:0] short_cmp, // Output below ground-short threshold
  input wire logic [NCH-1:0] single_cmp, // Output below selected level
  input wire logic [NCH-1:0] single_rel_cmp, // Output above level plus hysteresis
  input wire logic [NCH-1:0] chan_single_thresh_sel, // 0 level a, 1 level b
  input wire logic [7:0] single_short_level_a, // Level code a
  input wire logic [7:0] single_short_level_b, // Level code b
  input wire logic single_short_enable, // Single-short detection enable
  input wire logic low_supply_cmp, // Supply below low_supply_threshold
  input wire lfd_global_s global_fault, // Other detector levels
  input wire lfd_mask_s mask, // Fault type masks
  input wire logic [TIME_W-1:0] blank_cycles, // Blanking time in cycles
  input wire logic [TIME_W-1:0] open_deg_cycles, // Open deglitch cycles
  input wire logic [TIME_W-1:0] short_deg_cycles, // Short deglitch cycles
  input wire logic [TIME_W-1:0] single_deg_cycles, // Single-short deglitch cycles
  input wire logic fault_clear_bit, // Host write of 1 to clear
  input wire logic restore_defaults_bit, // Host write of 1 to reload
  input wire logic eep_start, // Initial load done, start check
  input wire logic eep_valid, // Byte of loaded config
  input wire logic [7:0] eep_byte, // Config byte
  input wire logic eep_is_reserved, // Byte is the reserved dimming reg
  input wire logic eep_last, // Last config byte
  input wire logic [7:0] stored_config_crc, // Stored CRC
  input wire logic trim_valid, // Trim word present
  input wire logic [8:0] trim_word, // Trim data plus even parity
  input wire logic bus_idle, // Serial bus idle
  input wire logic frame_ok, // Good addressed non-broadcast frame
  input wire logic [WDT_W-1:0] watchdog_period, // Watchdog period code
  input wire logic failsafe_clear_bit, // Host write of 1 to leave fail-safe
  output logic [NCH-1:0] chan_open_flag, // Latched open flags
  output logic [NCH-1:0] chan_short_flag, // Latched short flags
  output logic [NCH-1:0] chan_single_short_flag, // Latched single-short flags
  output logic [NCH-1:0] chan_single_active, // Single short currently present
  output logic [7:0] chan_level_code, // Level code in use by channel 0
  output logic out_flag, // Output summary flag
  output logic err_flag, // Error summary flag
  output logic low_supply_flag, // Latched low supply
  output logic supply_uv_flag, // Latched supply undervoltage
  output logic reference_flag, // Latched reference fault
  output logic prethermal_flag, // Latched pre-thermal warning
  output logic overtemp_flag, // Latched overtemperature
  output logic config_crc_fault_flag, // Latched config CRC mismatch
  output logic [7:0] computed_config_crc, // CRC over loaded config
  output logic trim_parity_flag, // Trim parity error
  output logic failsafe_flag, // Fail-safe state
  output logic clear_ack, // Clear bit read back, always 0
  output logic err_pin_o, // Error pin output level, always 0
  output logic err_pin_oe // High while pulling error pin low
);

  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      r = (r[7] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1); // [R15]
    end
    return r;
  endfunction

  function automatic logic qualify(input logic [TIME_W:0] cnt, input logic [TIME_W-1:0] b,
                                   input logic [TIME_W-1:0] g);
    return cnt > ({1'b0, b} + {1'b0, g});
  endfunction

  logic [NCH-1:0] open_evt, short_evt, single_evt;
  logic [NCH-1:0] next_open, next_short, next_single;

  // Per-channel qualification counters restart whenever the condition drops
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      logic [TIME_W:0] open_cnt, short_cnt, single_cnt, rel_cnt;
      logic open_go, short_go, single_go, rel_go;
      assign open_go = chan_pwm_on[ch] & chan_diag_enable[ch] & open_cmp[ch] & ~low_supply_cmp; // [R2] [R3] [R23]
      assign short_go = chan_pwm_on[ch] & chan_diag_enable[ch] & short_cmp[ch]; // [R7] [R23]
      assign single_go = chan_pwm_on[ch] & chan_diag_enable[ch] & single_short_enable
                         & single_cmp[ch] & ~low_supply_cmp; // [R8] [R10] [R23]
      assign rel_go = chan_pwm_on[ch] & single_rel_cmp[ch];

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          open_cnt <= '0;
          short_cnt <= '0;
          single_cnt <= '0;
          rel_cnt <= '0;
        end
        else
        begin
          // Saturate so a held fault never wraps back below the window
          open_cnt <= !open_go ? '0 : (&open_cnt ? open_cnt : open_cnt + 1'b1); // [R25]
          short_cnt <= !short_go ? '0 : (&short_cnt ? short_cnt : short_cnt + 1'b1); // [R25]
          single_cnt <= !single_go ? '0 : (&single_cnt ? single_cnt : single_cnt + 1'b1); // [R25]
          rel_cnt <= !rel_go ? '0 : (&rel_cnt ? rel_cnt : rel_cnt + 1'b1);
        end
      end

      assign open_evt[ch] = open_go & qualify(open_cnt, blank_cycles, open_deg_cycles); // [R1]
      assign short_evt[ch] = short_go & qualify(short_cnt, blank_cycles, short_deg_cycles); // [R6]
      assign single_evt[ch] = single_go & qualify(single_cnt, blank_cycles, single_deg_cycles); // [R9]

      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          chan_single_active[ch] <= 1'b0;
        else if (single_evt[ch])
          chan_single_active[ch] <= 1'b1;
        else if (low_supply_cmp || (rel_go && qualify(rel_cnt, blank_cycles, single_deg_cycles)))
          chan_single_active[ch] <= 1'b0; // [R13]
      end
    end
  endgenerate

  // Set wins over clear; no output action is taken on LED faults
  always_comb
  begin
    next_open = (fault_clear_bit ? '0 : chan_open_flag) | open_evt; // [R5] [R4]
    next_short = (fault_clear_bit ? '0 : chan_short_flag) | short_evt; // [R5]
    next_single = (fault_clear_bit ? '0 : chan_single_short_flag) | single_evt; // [R5]
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_open_flag <= '0;
      chan_short_flag <= '0;
      chan_single_short_flag <= '0;
    end
    else
    begin
      chan_open_flag <= next_open;
      chan_short_flag <= next_short;
      chan_single_short_flag <= next_single;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      chan_level_code <= '0;
    else
      chan_level_code <= chan_single_thresh_sel[0] ? single_short_level_b : single_short_level_a; // [R11] [R12]
  end

  // Global detector flags latch on level
  logic [4:0] glob_q, glob_lvl;
  assign glob_lvl = global_fault;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      glob_q <= '0;
    else
      glob_q <= (fault_clear_bit ? 5'h00 : glob_q) | glob_lvl; // [R5]
  end
  assign {low_supply_flag, supply_uv_flag, reference_flag, prethermal_flag, overtemp_flag} = glob_q;

  // CRC over loaded config bytes
  lfd_crc_state_e crc_state;
  logic [7:0] crc_acc;
  logic crc_evt;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crc_state <= LFD_CRC_IDLE;
      crc_acc <= CRC_INIT;
      computed_config_crc <= CRC_INIT;
    end
    else
    begin
      unique case (crc_state)
        LFD_CRC_IDLE:
          if (eep_start || restore_defaults_bit) // [R16]
          begin
            crc_acc <= CRC_INIT;
            crc_state <= LFD_CRC_RUN;
          end
        LFD_CRC_RUN:
          if (eep_valid)
          begin
            if (!eep_is_reserved)
              crc_acc <= crc_byte(crc_acc, eep_byte); // [R14]
            if (eep_last)
            begin
              computed_config_crc <= eep_is_reserved ? crc_acc : crc_byte(crc_acc, eep_byte); // [R14]
              crc_state <= LFD_CRC_DONE;
            end
          end
        LFD_CRC_DONE:
          crc_state <= LFD_CRC_IDLE;
        default:
          crc_state <= LFD_CRC_IDLE;
      endcase
    end
  end
  assign crc_evt = (crc_state == LFD_CRC_DONE) && (computed_config_crc != stored_config_crc); // [R14]

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_crc_fault_flag <= 1'b0;
      trim_parity_flag <= 1'b0;
    end
    else
    begin
      config_crc_fault_flag <= (fault_clear_bit ? 1'b0 : config_crc_fault_flag) | crc_evt; // [R5]
      trim_parity_flag <= (fault_clear_bit ? 1'b0 : trim_parity_flag) | (trim_valid & ^trim_word); // [R17]
    end
  end

  // Watchdog: prescaled ticks while idle, period code times tick
  logic [WDT_TICK_W-1:0] wdt_pre;
  logic [WDT_W-1:0] wdt_cnt;
  logic wdt_ovf;
  assign wdt_ovf = (watchdog_period == WDT_FORCE) ||
                   (watchdog_period != WDT_OFF && wdt_cnt >= watchdog_period); // [R20]
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_pre <= '0;
      wdt_cnt <= '0;
    end
    else if (frame_ok || watchdog_period == WDT_OFF || failsafe_flag)
    begin
      wdt_pre <= '0; // [R18]
      wdt_cnt <= '0;
    end
    else if (bus_idle)
    begin
      if (wdt_pre == WDT_TICK_W'(WDT_TICK - 1))
      begin
        wdt_pre <= '0;
        wdt_cnt <= wdt_cnt + 1'b1; // [R18]
      end
      else
        wdt_pre <= wdt_pre + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      failsafe_flag <= 1'b0;
    else if (wdt_ovf && !failsafe_flag)
      failsafe_flag <= 1'b1; // [R19]
    else if (failsafe_clear_bit && watchdog_period != WDT_FORCE)
      failsafe_flag <= 1'b0; // [R19]
  end

  // Summary flags and error pin honour per-type masks
  logic led_open_rep, led_short_rep, led_single_rep, pulse_evt, hold_lvl;
  assign led_open_rep = |open_evt & ~mask.open_f; // [R21] [R24]
  assign led_short_rep = |short_evt & ~mask.short_f; // [R21] [R24]
  assign led_single_rep = |single_evt & ~mask.single_short; // [R21] [R24]
  // Pulse only on a newly latched fault; a held fault must not retrigger it every PWM period
  logic led_new_rep;
  assign led_new_rep = (|(open_evt & ~chan_open_flag) & ~mask.open_f)
                       | (|(short_evt & ~chan_short_flag) & ~mask.short_f)
                       | (|(single_evt & ~chan_single_short_flag) & ~mask.single_short); // [R1] [R6] [R9]
  assign pulse_evt = led_new_rep
                     | (global_fault.low_supply & ~low_supply_flag & ~mask.low_supply)
                     | (global_fault.prethermal & ~prethermal_flag & ~mask.prethermal)
                     | (crc_evt & ~mask.config_crc); // [R22]
  assign hold_lvl = (global_fault.supply_uv & ~mask.supply_uv) | (global_fault.reference & ~mask.reference)
                    | (global_fault.overtemp & ~mask.overtemp); // [R22]

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_flag <= 1'b0;
      err_flag <= 1'b0;
      clear_ack <= 1'b0;
    end
    else
    begin
      out_flag <= (fault_clear_bit ? 1'b0 : out_flag) | led_open_rep | led_short_rep | led_single_rep; // [R24]
      err_flag <= (fault_clear_bit ? 1'b0 : err_flag) | pulse_evt | hold_lvl
                  | led_open_rep | led_short_rep | led_single_rep; // [R21]
      clear_ack <= 1'b0; // [R5]
    end
  end

  logic [TIME_W-1:0] pulse_cnt;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_cnt <= '0;
    else if (pulse_evt)
      pulse_cnt <= TIME_W'(ERR_CYC); // [R25]
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      err_pin_o <= 1'b0;
      err_pin_oe <= 1'b0;
    end
    else
    begin
      err_pin_o <= 1'b0;
      err_pin_oe <= pulse_evt | (pulse_cnt > TIME_W'(1)) | hold_lvl; // [R1] [R22]
    end
  end

endmodule // lfd_monitor

// ===== lfd_pkg.sv
// Package for the LED fault diagnosis monitor: timing, widths, encodings.
// Assumes a single 100 MHz clock shared by every user of these constants.
package lfd_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ERR_PULSE_US = 50;
  localparam int ERR_PULSE_CYC = ERR_PULSE_US * CLK_MHZ;
  localparam int NUM_CHAN = 16;
  localparam int TIME_W = 16;
  localparam int WDT_W = 4;
  localparam int CRC_W = 8;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [3:0] WDT_OFF = 4'h0;
  localparam logic [3:0] WDT_FORCE = 4'hF;
  localparam int WDT_TICK_DEF = 100000;
  localparam int WDT_TICK_W = 20;
  localparam logic [7:0] SLS_HYST_CODES = 8'h03;

  typedef enum logic [1:0] {
    LFD_CRC_IDLE = 2'b00,
    LFD_CRC_RUN = 2'b01,
    LFD_CRC_DONE = 2'b10
  } lfd_crc_state_e;

  typedef struct packed {
    logic low_supply;
    logic supply_uv;
    logic reference;
    logic prethermal;
    logic overtemp;
    logic config_crc;
    logic open_f;
    logic short_f;
    logic single_short;
  } lfd_mask_s;

  typedef struct packed {
    logic low_supply;
    logic supply_uv;
    logic reference;
    logic prethermal;
    logic overtemp;
  } lfd_global_s;
endpackage

// ===== lfd_monitor_sva.sv
// Checker for lfd_monitor: flag causes, latching, error pin, watchdog.
// Assumes it is bound into lfd_monitor with its parameters handed on.
`timescale 1ns/100ps
module lfd_monitor_sva
  import lfd_pkg::*;
#(
  parameter int NCH = NUM_CHAN,
  parameter int ERR_CYC = ERR_PULSE_CYC,
  parameter int WDT_TICK = WDT_TICK_DEF
)
(
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [NCH-1:0] chan_pwm_on, // On-time
  input wire logic [NCH-1:0] chan_diag_enable, // Diag enable
  input wire logic [NCH-1:0] open_cmp, // Open level
  input wire logic [NCH-1:0] single_cmp, // Single level
  input wire logic single_short_enable, // Single enable
  input wire logic low_supply_cmp, // Low supply level
  input wire lfd_global_s global_fault, // Other detectors
  input wire lfd_mask_s mask, // Masks
  input wire logic fault_clear_bit, // Clear strobe
  input wire logic [WDT_W-1:0] watchdog_period, // Period code
  input wire logic [NCH-1:0] chan_open_flag, // Open flags
  input wire logic [NCH-1:0] chan_single_short_flag, // Single flags
  input wire logic [NCH-1:0] chan_single_active, // Single short present
  input wire logic out_flag, // Output summary
  input wire logic err_flag, // Error summary
  input wire logic low_supply_flag, // Low supply flag
  input wire logic failsafe_flag, // Fail-safe
  input wire logic err_pin_o, // Pin level
  input wire logic err_pin_oe // Pin pull enable
);
  logic open_go;
  logic single_go;
  assign open_go = open_cmp[0] & chan_pwm_on[0] & chan_diag_enable[0] & ~low_supply_cmp;
  assign single_go = single_cmp[0] & chan_pwm_on[0] & chan_diag_enable[0] & ~low_supply_cmp & single_short_enable;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_uv_held;
    (global_fault.supply_uv && !mask.supply_uv) [*3];
  endsequence
  sequence s_ls_held;
    global_fault.low_supply [*3];
  endsequence
  a_open_cause: assert property ($rose(chan_open_flag[0]) |-> $past(open_go, 2))
    else $error("open flag without a qualified cause");
  a_single_cause: assert property ($rose(chan_single_short_flag[0]) |-> $past(single_go, 2))
    else $error("single flag without a qualified cause");
  a_flag_holds: assert property (chan_open_flag[0] && !fault_clear_bit |=> chan_open_flag[0])
    else $error("open flag dropped without clear");
  a_clear_drops: assert property (fault_clear_bit && !(|chan_pwm_on) && !$past(|chan_pwm_on)
    && !$past(|chan_pwm_on, 2) |=> !chan_open_flag[0] && !out_flag)
    else $error("clear did not drop flags");
  a_single_release: assert property (low_supply_cmp |=> !chan_single_active[0])
    else $error("single short still present under low supply");
  a_summary_pair: assert property ($rose(out_flag) |-> err_flag)
    else $error("output summary without error summary");
  a_pulse_min: assert property ($rose(err_pin_oe) |-> err_pin_oe [*8])
    else $error("error pin pulse too short");
  a_pin_only_low: assert property (err_pin_oe |-> !err_pin_o)
    else $error("error pin driven high");
  a_uv_holds: assert property (s_uv_held |-> err_pin_oe)
    else $error("undervoltage does not hold error pin");
  a_ls_latch: assert property (s_ls_held |-> low_supply_flag)
    else $error("low supply flag not latched");
  a_wdt_force: assert property ((watchdog_period == WDT_FORCE) [*3] |-> failsafe_flag)
    else $error("forced period without fail-safe");
endmodule // lfd_monitor_sva

// ===== lfd_host_model.sv
// Host model: turns bench requests into one-cycle register write strobes.
// Assumes a request is held for one cycle; gap sets how slow the host is.
`timescale 1ns/100ps
module lfd_host_model
(
  input wire logic ref_clk, // Clock
  input wire logic [2:0] req, // Clear, fail-safe clear, good frame
  input wire logic [3:0] gap, // Extra cycles before the write lands
  output logic fault_clear_bit, // Clear strobe
  output logic failsafe_clear_bit, // Fail-safe clear strobe
  output logic frame_ok // Good addressed frame
);
  logic [2:0] held;
  initial {fault_clear_bit, failsafe_clear_bit, frame_ok} = 3'h0;
  always @(negedge ref_clk)
    if (|req)
    begin
      // Request lasts one cycle only, so keep it across the gap
      held = req;
      repeat (gap) @(negedge ref_clk);
      {fault_clear_bit, failsafe_clear_bit, frame_ok} <= held;
      @(negedge ref_clk);
      {fault_clear_bit, failsafe_clear_bit, frame_ok} <= 3'h0; // Written 1 returns to 0
    end
endmodule // lfd_host_model

// ===== tb.sv
// Self-checking bench for lfd_monitor with a host model.
// Assumes shortened error pulse (20) and watchdog tick (4) counts.
`timescale 1ns/100ps
module tb;
  import lfd_pkg::*;
  localparam int NC = 2;
  logic ref_clk, rst_n, sen, lsc, estart, evalid, eres, elast, tvalid, idle, fclr, fsclr, fok, rdef;
  logic [NC-1:0] pwm, diag, ocmp, scmp, lcmp, tsel, of, sf, lf;
  logic [7:0] lva, lvb, ebyte, scrc, ccrc, lvc, crc;
  logic [8:0] tword;
  logic [3:0] wdp, gap;
  logic [2:0] req;
  logic [15:0] bl, dg;
  lfd_global_s gf;
  lfd_mask_s msk;
  logic ofl, efl, cfl, tpf, fsf;
  logic [23:0] expq[$];
  int n_errors = 0, n_tests = 0, cyc = 0;
  event chk;
  lfd_monitor #(.NCH(NC), .ERR_CYC(20), .WDT_TICK(4)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .chan_pwm_on(pwm), .chan_diag_enable(diag), .open_cmp(ocmp), .short_cmp(scmp), .single_cmp(lcmp),
    .single_rel_cmp(~lcmp), .chan_single_thresh_sel(tsel), .single_short_level_a(lva),
    .single_short_level_b(lvb), .single_short_enable(sen), .low_supply_cmp(lsc), .global_fault(gf),
    .mask(msk), .blank_cycles(bl), .open_deg_cycles(dg), .short_deg_cycles(dg), .single_deg_cycles(dg),
    .fault_clear_bit(fclr), .restore_defaults_bit(rdef), .eep_start(estart), .eep_valid(evalid),
    .eep_byte(ebyte), .eep_is_reserved(eres), .eep_last(elast), .stored_config_crc(scrc),
    .trim_valid(tvalid), .trim_word(tword), .bus_idle(idle), .frame_ok(fok), .watchdog_period(wdp),
    .failsafe_clear_bit(fsclr), .chan_open_flag(of), .chan_short_flag(sf), .chan_single_short_flag(lf),
    .chan_single_active(), .chan_level_code(lvc), .out_flag(ofl), .err_flag(efl), .low_supply_flag(),
    .supply_uv_flag(), .reference_flag(), .prethermal_flag(), .overtemp_flag(),
    .config_crc_fault_flag(cfl), .computed_config_crc(ccrc), .trim_parity_flag(tpf),
    .failsafe_flag(fsf), .clear_ack(), .err_pin_o(), .err_pin_oe());
  lfd_host_model i_host (.ref_clk(ref_clk), .req(req), .gap(gap), .fault_clear_bit(fclr),
    .failsafe_clear_bit(fsclr), .frame_ok(fok));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c[7] ^ d[i]) ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0}; // MSB first
    return c;
  endfunction
  task automatic tick(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic note(logic [7:0] f);
    expq.push_back({tsel[0] ? lvb : lva, crc, f});
    -> chk;
  endtask
  task automatic cmp_state(logic [23:0] e, logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  always @(chk)
    cmp_state(expq.pop_front(), {lvc, ccrc, of[0], sf[0], lf[0], ofl, efl, cfl, tpf, fsf});
  task automatic pulse(int t, int len);
    pwm[0] = 1'b1;
    ocmp[0] = (t == 0);
    scmp[0] = (t == 1);
    lcmp[0] = (t == 2);
    tick(len);
    {pwm[0], ocmp[0], scmp[0], lcmp[0]} = 4'h0;
    tick(4);
  endtask
  task automatic host(logic [2:0] r);
    gap <= 4'($urandom % 4);
    req <= r;
    tick(1);
    req <= 3'h0;
    tick(int'(gap) + 3);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  initial
  begin
    void'($urandom(10));
    {rst_n, pwm, ocmp, scmp, lcmp, sen, lsc, estart, evalid, eres, elast, tvalid, idle, rdef} = '0;
    {req, wdp, gap, gf, msk, tword, ebyte, scrc} = '0;
    diag = '1;
    tsel = NC'($urandom);
    lva = 8'($urandom);
    lvb = 8'($urandom);
    bl = 16'(1 + $urandom % 2);
    dg = 16'(3 + $urandom % 2);
    crc = 8'hFF;
    tick(10);
    rst_n = 1'b1;
    tick(2);
    note(8'h00);
    for (int t = 0; t < 3; t++)
      for (int m = 0; m < 2; m++)
      begin
        msk = 9'(m << (2 - t));
        sen = 1'b1;
        tsel[0] = ~tsel[0];
        pulse(t, 2 + $urandom % 2);
        note(8'h00); // Short on-time ignored, level select
        pulse(t, 9 + $urandom % 4);
        note(8'(8'h80 >> t) | (m == 1 ? 8'h00 : 8'h18));
        host(3'b100);
        note(8'h00);
      end
    msk = '0;
    lsc = 1'b1;
    pulse(0, 12);
    pulse(2, 12);
    lsc = 1'b0;
    diag[0] = 1'b0;
    for (int t = 0; t < 3; t++)
      pulse(t, 12);
    diag[0] = 1'b1;
    sen = 1'b0;
    pulse(2, 12);
    note(8'h00);
    for (int k = 0; k < 2; k++)
    begin
      estart = (k == 0);
      rdef = (k == 1);
      tick(1);
      {estart, rdef} = 2'h0;
      crc = 8'hFF;
      for (int b = 0; b < 5; b++)
      begin
        ebyte = 8'($urandom);
        {eres, elast, evalid} = {b == 2, b == 4, 1'b1};
        if (b != 2)
          crc = crc8(crc, ebyte); // Reserved byte skipped
        scrc = crc ^ 8'(k);
        tick(1);
        {eres, elast, evalid} = 3'h0;
        tick(1);
      end
      tick(4);
      note(k == 1 ? 8'h0C : 8'h00);
    end
    for (int p = 0; p < 2; p++)
    begin
      tword[7:0] = 8'($urandom);
      tword[8] = (^tword[7:0]) ^ p[0];
      tvalid = 1'b1;
      tick(1);
      tvalid = 1'b0;
      tick(3);
      note(8'h0C | 8'(p << 1)); // CRC flags still latched; odd count is a parity error
    end
    host(3'b100);
    note(8'h00);
    {idle, wdp} = {1'b1, 4'h4};
    repeat (8)
      host(3'b001);
    note(8'h00);
    tick(30);
    note(8'h01);
    idle = 1'b0;
    host(3'b010);
    note(8'h00);
    wdp = 4'hF;
    tick(3);
    note(8'h01);
    {idle, wdp} = {1'b1, 4'h0};
    host(3'b010);
    tick(100);
    note(8'h00); // Period 0 never overflows
    gf.supply_uv = 1'b1;
    tick(10);
    gf = '0;
    gf.low_supply = 1'b1;
    tick(4);
    gf = '0;
    tick(25);
    note(8'h08); // Held and pulsed faults latch the error summary
    host(3'b100);
    note(8'h00);
    tick(5);
    end_of_test();
  end
endmodule // tb
bind lfd_monitor lfd_monitor_sva #(.NCH(NCH), .ERR_CYC(ERR_CYC), .WDT_TICK(WDT_TICK)) i_sva (.*);
